// ==== common/tsr_pkg.sv ====
// Shared constants and types for the temperature result and status block
`default_nettype none

package tsr_pkg;

  // ----------------------------------------------------------------
  // Register addresses seen through the address pointer
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RES_HI = 8'h00;
  localparam logic [7:0] ADDR_RES_LO = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_SETUP  = 8'h03;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] PTR_RESET    = 8'h00;
  localparam logic [7:0] SETUP_RESET  = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic       RDY_N_RESET  = 1'b1;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SIGN_BIT     = 15;
  localparam int SETUP_RES    = 7;
  localparam int SETUP_MODE_H = 6;
  localparam int SETUP_MODE_L = 5;
  localparam int SETUP_CMP    = 4;
  localparam int ST_RDY_N     = 7;
  localparam int ST_CRIT      = 6;
  localparam int ST_HIGH      = 5;
  localparam int ST_LOW       = 4;
  localparam int LSB_CRIT     = 2;
  localparam int LSB_HIGH     = 1;
  localparam int LSB_LOW      = 0;
  localparam int FLAG_BITS    = 3;

  // Hysteresis is whole degrees; one degree is 128 codes of the 16-bit word
  localparam int HYST_SHIFT   = 7;

  // ----------------------------------------------------------------
  // Operating mode encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_CONT     = 2'b00;
  localparam logic [1:0] MODE_ONE_SHOT = 2'b01;
  localparam logic [1:0] MODE_SPS1     = 2'b10;
  localparam logic [1:0] MODE_SHUTDOWN = 2'b11;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TSR_OP_PTR,
    TSR_OP_WR,
    TSR_OP_RD
  } tsr_op_e;

  typedef struct packed {
    tsr_op_e    op;
    logic [7:0] data;
  } tsr_req_s;

  typedef struct packed {
    logic [15:0] high_limit;
    logic [15:0] low_limit;
    logic [15:0] critical_limit;
    logic [7:0]  hysteresis_margin;
  } tsr_limits_s;

endpackage : tsr_pkg

`default_nettype wire

// ==== logic/tsr_pulse_sync.sv ====
// Toggle based single-pulse crossing between two clock domains
`default_nettype none

module tsr_pulse_sync
  import tsr_pkg::*;
(
  input  wire logic src_clk,
  input  wire logic src_rst,
  input  wire logic src_pulse,
  input  wire logic dst_clk,
  input  wire logic dst_rst,
  output logic      dst_pulse
);

  logic toggle_reg;
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;

  always_ff @(posedge src_clk or posedge src_rst) begin
    if (src_rst) begin
      toggle_reg <= 1'b0;
    end else if (src_pulse) begin
      toggle_reg <= ~toggle_reg;
    end
  end

  // First stage feeds only the second; edge taken between stages two and three
  always_ff @(posedge dst_clk or posedge dst_rst) begin
    if (dst_rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= toggle_reg;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign dst_pulse = sync2_reg ^ sync3_reg;

endmodule : tsr_pulse_sync

`default_nettype wire

// ==== logic/tsr_result_status.sv ====
// Temperature result, status and setup registers behind the address pointer
//
// Function
// [R1] Result word is two's complement; bit 15 of the word is the sign.
// [R2] Controller reads the high byte at 0x00 before the low byte at 0x01.
// [R3] Reading the high byte moves the pointer on to the low byte by itself.
// [R4] 13-bit mode: result bits 0..2 are flags; 16-bit mode: temperature LSBs.
// [R5] 13-bit comparator mode: bit 0 reads 1 while below the low limit.
// [R6] 13-bit comparator mode: bit 1 reads 1 while above high limit, else 0.
// [R7] 13-bit comparator mode: bit 2 reads 1 above critical limit, else 0.
// [R8] High byte holds sign and bits 14..8, low byte bits 7..3; reset zero, RO.
// [R9] Status is an eight-bit read-only register of alarm flags and progress.
// [R10] Status bit 4 sets below low limit; clears on read or above low+hyst. Code sets it in comparator mode only.
// [R11] Status bit 5 sets above high limit; clears on read or below high-hyst. Code sets it in comparator mode only.
// [R12] Status bit 6 sets above critical; clears on read or below critical-hyst. Code sets it in comparator mode only.
// [R13] Status bit 7 resets to 1 and drops to 0 when a result is written.
// [R14] Status bit 7 returns to 1 when the result register is read.
// [R15] In one-shot and 1 SPS modes a mode write returns bit 7 to 1.
// [R16] Status bits 3..0 always read zero.
// [R17] Setup bit 4 picks interrupt mode (0) or comparator mode (1).
// [R18] Setup bit 7 picks 13-bit (0) or 16-bit (1) resolution.
// [R19] Setup bits 6..5: continuous, one-shot, one per second, shutdown.
// [R20] Address pointer comes up as zero, selecting the high result byte.
// [R21] Writes to result and status registers are ignored.
`default_nettype none

module tsr_result_status
  import tsr_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         link_clk,
  input  wire logic         link_rst,
  // Register access from the bus controller, link clock domain
  input  wire logic         req_valid,
  output logic              req_ready,
  input  wire tsr_req_s     req,
  output logic              rsp_valid,
  output logic [7:0]        rsp_data,
  // Converter side, core clock domain
  input  wire logic         conv_valid,
  input  wire logic [15:0]  conv_value,
  input  wire tsr_limits_s  limits,
  output logic              res_16bit,
  output logic              comparator_mode,
  output logic [1:0]        op_mode,
  output logic              one_shot_kick
);

  // ----------------------------------------------------------------
  // Link side: hold one request until the core answers
  // ----------------------------------------------------------------
  tsr_req_s   req_hold_reg;
  logic       busy_reg;
  logic       rsp_valid_reg;
  logic [7:0] rsp_data_reg;
  logic       take;
  logic       ack_link;
  logic [7:0] rd_data_reg;
  assign req_ready = ~busy_reg;
  assign take      = req_valid & req_ready;
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      req_hold_reg <= '{op: TSR_OP_PTR, data: PTR_RESET};
    end else if (take) begin
      req_hold_reg <= req;
    end
  end

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      busy_reg <= 1'b0;
    end else if (take) begin
      busy_reg <= 1'b1;
    end else if (ack_link) begin
      busy_reg <= 1'b0;
    end
  end

  // Read data is stable in the core until the next request, which waits for this
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg  <= RESULT_RESET;
    end else begin
      rsp_valid_reg <= ack_link;
      if (ack_link) begin
        rsp_data_reg <= rd_data_reg;
      end
    end
  end

  assign rsp_valid = rsp_valid_reg;
  assign rsp_data  = rsp_data_reg;

  // ----------------------------------------------------------------
  // Domain crossings
  // ----------------------------------------------------------------
  logic cmd_pulse;
  logic ack_core_reg;
  tsr_pulse_sync u_req_sync (
    .src_clk   (link_clk),
    .src_rst   (link_rst),
    .src_pulse (take),
    .dst_clk   (clk),
    .dst_rst   (rst),
    .dst_pulse (cmd_pulse)
  );
  tsr_pulse_sync u_ack_sync (
    .src_clk   (clk),
    .src_rst   (rst),
    .src_pulse (ack_core_reg),
    .dst_clk   (link_clk),
    .dst_rst   (link_rst),
    .dst_pulse (ack_link)
  );

  // ----------------------------------------------------------------
  // Core side decode
  // ----------------------------------------------------------------
  logic [7:0] ptr_reg;
  logic [7:0] setup_reg;
  logic [7:0] res_hi_reg;
  logic [7:0] res_lo_reg;
  logic       flag_low_reg;
  logic       flag_high_reg;
  logic       flag_crit_reg;
  logic       rdy_n_reg;
  logic       shot_kick_reg;
  logic wr_ptr;
  logic wr_byte;
  logic rd_byte;
  logic rd_status;
  logic rd_result;
  logic setup_wr;
  logic shot_mode_wr;

  assign wr_ptr    = cmd_pulse && (req_hold_reg.op == TSR_OP_PTR);
  assign wr_byte   = cmd_pulse && (req_hold_reg.op == TSR_OP_WR);
  assign rd_byte   = cmd_pulse && (req_hold_reg.op == TSR_OP_RD);
  assign rd_status = rd_byte && (ptr_reg == ADDR_STATUS);
  assign rd_result = rd_byte && (ptr_reg == ADDR_RES_HI || ptr_reg == ADDR_RES_LO);
  // Only the setup register takes data; result and status writes fall away
  assign setup_wr  = wr_byte && (ptr_reg == ADDR_SETUP); // R21
  assign shot_mode_wr = setup_wr &&
      (req_hold_reg.data[SETUP_MODE_H:SETUP_MODE_L] == MODE_ONE_SHOT ||
       req_hold_reg.data[SETUP_MODE_H:SETUP_MODE_L] == MODE_SPS1); // R15
  assign res_16bit       = setup_reg[SETUP_RES]; // R18
  assign comparator_mode = setup_reg[SETUP_CMP]; // R17
  assign op_mode         = setup_reg[SETUP_MODE_H:SETUP_MODE_L]; // R19
  assign one_shot_kick   = shot_kick_reg;

  // ----------------------------------------------------------------
  // Pointer and setup register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_reg <= PTR_RESET; // R20
    end else if (wr_ptr) begin
      ptr_reg <= req_hold_reg.data;
    end else if (rd_byte && ptr_reg == ADDR_RES_HI) begin
      ptr_reg <= ADDR_RES_LO; // R3
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      setup_reg <= SETUP_RESET;
    end else if (setup_wr) begin
      setup_reg <= req_hold_reg.data;
    end
  end

  // Converter starts a one-shot sample on this pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shot_kick_reg <= 1'b0;
    end else begin
      shot_kick_reg <= setup_wr &&
          (req_hold_reg.data[SETUP_MODE_H:SETUP_MODE_L] == MODE_ONE_SHOT); // R19
    end
  end

  // ----------------------------------------------------------------
  // Limit comparison
  // ----------------------------------------------------------------
  function automatic logic signed [16:0] sext(input logic [15:0] v);
    sext = signed'({v[SIGN_BIT], v});
  endfunction : sext
  function automatic logic signed [16:0] hyst_codes(input logic [7:0] h);
    hyst_codes = signed'({2'b00, h, 7'h00});
  endfunction : hyst_codes

  logic signed [16:0] temp_s;
  logic below_low;
  logic above_high;
  logic above_crit;
  logic back_low;
  logic back_high;
  logic back_crit;
  // In 13-bit mode the three low bits are not part of the measurement
  always_comb begin
    temp_s = sext(res_16bit ? conv_value : {conv_value[15:FLAG_BITS], 3'b000}); // R4
    below_low  = temp_s < sext(limits.low_limit);
    above_high = temp_s > sext(limits.high_limit);
    above_crit = temp_s > sext(limits.critical_limit);
    back_low   = temp_s > (sext(limits.low_limit) + hyst_codes(limits.hysteresis_margin));
    back_high  = temp_s < (sext(limits.high_limit) - hyst_codes(limits.hysteresis_margin));
    back_crit  = temp_s < (sext(limits.critical_limit) - hyst_codes(limits.hysteresis_margin));
  end
  logic set_low;
  logic set_high;
  logic set_crit;
  assign set_low  = conv_valid && comparator_mode && below_low;  // R10
  assign set_high = conv_valid && comparator_mode && above_high; // R11
  assign set_crit = conv_valid && comparator_mode && above_crit; // R12

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      res_hi_reg <= RESULT_RESET; // R8
      res_lo_reg <= RESULT_RESET;
    end else if (conv_valid) begin
      res_hi_reg <= conv_value[15:8]; // R1 R8
      if (res_16bit) begin
        res_lo_reg <= conv_value[7:0]; // R4 R6 R7
      end else begin
        res_lo_reg[7:FLAG_BITS] <= conv_value[7:FLAG_BITS]; // R8
        res_lo_reg[LSB_CRIT]    <= set_crit; // R7
        res_lo_reg[LSB_HIGH]    <= set_high; // R6
        res_lo_reg[LSB_LOW]     <= set_low;  // R5
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags: an event in the clearing cycle keeps the flag set
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_low_reg <= 1'b0;
    end else if (set_low) begin
      flag_low_reg <= 1'b1;
    end else if (rd_status || (conv_valid && back_low)) begin
      flag_low_reg <= 1'b0; // R10
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_high_reg <= 1'b0;
    end else if (set_high) begin
      flag_high_reg <= 1'b1;
    end else if (rd_status || (conv_valid && back_high)) begin
      flag_high_reg <= 1'b0; // R11
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_crit_reg <= 1'b0;
    end else if (set_crit) begin
      flag_crit_reg <= 1'b1;
    end else if (rd_status || (conv_valid && back_crit)) begin
      flag_crit_reg <= 1'b0; // R12
    end
  end

  // A fresh result beats a simultaneous read, so the new value is not missed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdy_n_reg <= RDY_N_RESET; // R13
    end else if (conv_valid) begin
      rdy_n_reg <= 1'b0; // R13
    end else if (rd_result || shot_mode_wr) begin
      rdy_n_reg <= 1'b1; // R14 R15
    end
  end

  // ----------------------------------------------------------------
  // Read mux and answer
  // ----------------------------------------------------------------
  logic [7:0] status_byte;
  logic [7:0] rd_mux;
  always_comb begin
    status_byte           = 8'h00; // R16
    status_byte[ST_RDY_N] = rdy_n_reg; // R9
    status_byte[ST_CRIT]  = flag_crit_reg;
    status_byte[ST_HIGH]  = flag_high_reg;
    status_byte[ST_LOW]   = flag_low_reg;
    case (ptr_reg)
      ADDR_RES_HI: rd_mux = res_hi_reg;
      ADDR_RES_LO: rd_mux = res_lo_reg;
      ADDR_STATUS: rd_mux = status_byte;
      ADDR_SETUP:  rd_mux = setup_reg;
      default:     rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_reg <= RESULT_RESET;
    end else if (rd_byte) begin
      rd_data_reg <= rd_mux;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_core_reg <= 1'b0;
    end else begin
      ack_core_reg <= cmd_pulse;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_rdy_goes_low: assert property (conv_valid |=> !rdy_n_reg) // R13
    else $error("ready bit did not drop after a result write");
  a_rdy_read_back: assert property (rd_result && !conv_valid |=> rdy_n_reg) // R14
    else $error("ready bit not restored by a result read");
  a_rdy_shot_write: assert property (shot_mode_wr && !conv_valid |=> rdy_n_reg) // R15
    else $error("ready bit not restored by a mode write");
  a_status_low_zero: assert property (rd_status |=> rd_data_reg[3:0] == 4'h0) // R16
    else $error("unused status bits read nonzero");
  a_ptr_auto_inc: assert property ( // R3
      rd_byte && ptr_reg == ADDR_RES_HI |=> ptr_reg == ADDR_RES_LO)
    else $error("pointer did not advance to the low result byte");
  a_ro_write_ignored: assert property ( // R21
      wr_byte && ptr_reg != ADDR_SETUP && !conv_valid
      |=> $stable(res_hi_reg) && $stable(res_lo_reg) && $stable(setup_reg))
    else $error("write to a read-only register changed state");
  a_result_word: assert property ( // R1
      conv_valid |=> {res_hi_reg, res_lo_reg[7:FLAG_BITS]} == $past(conv_value[15:3]))
    else $error("result bytes do not match the conversion");
  a_lsb_flags: assert property ( // R4
      conv_valid && !res_16bit |=> res_lo_reg[2:0] == $past({set_crit, set_high, set_low}))
    else $error("low result flags wrong in 13-bit mode");
  a_lsb_data: assert property ( // R4
      conv_valid && res_16bit |=> res_lo_reg[2:0] == $past(conv_value[2:0]))
    else $error("low result bits wrong in 16-bit mode");
  a_low_flag_set: assert property (set_low |=> flag_low_reg) // R10
    else $error("low flag not set below the limit");
  a_high_read_clear: assert property (rd_status && !set_high |=> !flag_high_reg) // R11
    else $error("high flag survived a status read");
  // A clear cause seen one cycle after the set explains the flag dropping
  a_crit_flag_set: assert property ( // R12
      set_crit |=> flag_crit_reg ##1 (flag_crit_reg || $past(rd_status || conv_valid)))
    else $error("critical flag lost without a clear cause");
  a_answer_follows: assert property (cmd_pulse |=> ack_core_reg) // R9
    else $error("request not answered in one cycle");

  c_result_then_read: cover property (conv_valid ##[1:20] rd_result);
  c_status_clear: cover property (flag_high_reg ##[1:20] rd_status);
  c_shot_write: cover property (shot_mode_wr);

endmodule : tsr_result_status

`default_nettype wire

// ==== verification/tsr_ctrl_model.sv ====
// Bus controller model that issues register requests on the link clock
`default_nettype none

module tsr_ctrl_model
  import tsr_pkg::*;
(
  input  wire logic       link_clk,
  input  wire logic       req_ready,
  input  wire logic       rsp_valid,
  input  wire logic [7:0] rsp_data,
  output var logic        req_valid,
  output var tsr_req_s    req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    req_valid = 1'b0;
    req       = '0;
  end

  // ----------------------------------------
  // One request, held until taken
  // ----------------------------------------
  task automatic xfer(input tsr_op_e op, input logic [7:0] d, output logic [7:0] q);
    int n;
    q = 'x;
    // Random idle gap so the block sees slow and prompt controllers
    repeat ($urandom_range(2, 0)) @(posedge link_clk);
    @(posedge link_clk);
    req_valid <= 1'b1;
    req.op    <= op;
    req.data  <= d;
    n = 0;
    do begin
      @(negedge link_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 40);
    @(posedge link_clk);
    req_valid <= 1'b0;
    // Released data does not keep the old value
    req.data  <= ~d;
    n = 0;
    do begin
      @(negedge link_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 40);
    if (rsp_valid === 1'b1) q = rsp_data;
  endtask : xfer

  // Pointer loaded once; high byte first, then the low byte
  task automatic read_word(output logic [15:0] w);
    logic [7:0] d;
    xfer(TSR_OP_PTR, ADDR_RES_HI, d);
    xfer(TSR_OP_RD, 8'h00, w[15:8]);
    xfer(TSR_OP_RD, 8'h00, w[7:0]);
  endtask : read_word

endmodule : tsr_ctrl_model

`default_nettype wire

// ==== verification/tb_temperature_result_status_regs.sv ====
// Self-checking bench for the temperature result and status registers
`default_nettype none

module tb_temperature_result_status_regs;
  import tsr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        rst, link_rst, req_valid, req_ready, rsp_valid, conv_valid;
  logic        res_16bit, comparator_mode, one_shot_kick, m_rdy_n;
  logic [1:0]  op_mode;
  logic [2:0]  m_flg;
  logic [7:0]  rsp_data, m_setup, m_ptr, s;
  logic [15:0] conv_value, m_res;
  tsr_req_s    req;
  tsr_limits_s limits;
  int          n_fail, cmp_count, kick_cnt;
  logic [7:0]  ro [4] = '{ADDR_RES_HI, ADDR_RES_LO, ADDR_STATUS, 8'h10};

  always #5 clk = ~clk;
  initial begin
    #4;
    forever #15 link_clk = ~link_clk;
  end
  always @(posedge clk) if (one_shot_kick === 1'b1) kick_cnt <= kick_cnt + 1;

  tsr_result_status i_tsr_result_status (
    .clk(clk), .rst(rst), .link_clk(link_clk), .link_rst(link_rst),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .conv_valid(conv_valid),
    .conv_value(conv_value), .limits(limits), .res_16bit(res_16bit),
    .comparator_mode(comparator_mode), .op_mode(op_mode), .one_shot_kick(one_shot_kick)
  );

  tsr_ctrl_model i_tsr_ctrl_model (
    .link_clk(link_clk), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .req_valid(req_valid), .req(req)
  );

  // ----------------------------------------
  // Checking and verdict
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  function automatic logic [7:0] m_read();
    logic [7:0] r;
    case (m_ptr)
      ADDR_RES_HI: begin
        r = m_res[15:8];
        m_rdy_n = 1'b1;
        m_ptr = ADDR_RES_LO;
      end
      ADDR_RES_LO: begin
        r = m_res[7:0];
        m_rdy_n = 1'b1;
      end
      ADDR_STATUS: begin
        r = {m_rdy_n, m_flg, 4'h0};
        m_flg = 3'b000;
      end
      ADDR_SETUP: r = m_setup;
      default: r = 8'h00;
    endcase
    return r;
  endfunction : m_read

  // Limits sit between 13-bit codes so no 13-bit value can equal one
  function automatic logic [15:0] rnd16(input bit lim);
    logic [15:0] v;
    v = 16'(int'($urandom_range(3000, 0)) - 1500);
    return lim ? {v[15:3], 3'b100} : v;
  endfunction : rnd16

  task automatic do_conv(input logic [15:0] v);
    int t;
    int h;
    logic [2:0] c;
    @(posedge clk);
    conv_valid <= 1'b1;
    conv_value <= v;
    t = $signed(m_setup[SETUP_RES] ? v : {v[15:3], 3'b000});
    h = 128 * limits.hysteresis_margin;
    c = {t > $signed(limits.critical_limit), t > $signed(limits.high_limit),
         t < $signed(limits.low_limit)};
    if (t > $signed(limits.low_limit) + h) m_flg[0] = 1'b0;
    if (t < $signed(limits.high_limit) - h) m_flg[1] = 1'b0;
    if (t < $signed(limits.critical_limit) - h) m_flg[2] = 1'b0;
    if (m_setup[SETUP_CMP]) m_flg = m_flg | c;
    m_res = m_setup[SETUP_RES] ? v : {v[15:3], m_setup[SETUP_CMP] ? c : 3'b000};
    m_rdy_n = 1'b0;
    @(posedge clk);
    conv_valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : do_conv

  task automatic acc(input tsr_op_e op, input logic [7:0] d);
    logic [7:0] q;
    int k;
    k = kick_cnt;
    i_tsr_ctrl_model.xfer(op, d, q);
    if (op == TSR_OP_PTR) m_ptr = d;
    if (op == TSR_OP_RD) chk(q, m_read(), "register read");
    if (op == TSR_OP_WR && m_ptr == ADDR_SETUP) begin
      m_setup = d;
      if (d[6:5] == MODE_ONE_SHOT || d[6:5] == MODE_SPS1) m_rdy_n = 1'b1;
      repeat (4) @(posedge clk);
      chk({res_16bit, comparator_mode, op_mode}, {d[7], d[4], d[6:5]}, "setup");
      chk(16'(kick_cnt - k), 16'(d[6:5] == MODE_ONE_SHOT), "kick count");
    end
  endtask : acc

  task automatic rd_word();
    logic [15:0] w;
    i_tsr_ctrl_model.read_word(w);
    m_ptr = ADDR_RES_LO;
    m_rdy_n = 1'b1;
    chk(w, m_res, "result word");
  endtask : rd_word

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h3391_d86c));
    rst = 1'b1;
    link_rst = 1'b1;
    conv_valid = 1'b0;
    conv_value = 16'h0000;
    limits = '0;
    m_setup = SETUP_RESET;
    m_ptr = PTR_RESET;
    m_res = {RESULT_RESET, RESULT_RESET};
    m_flg = 3'b000;
    m_rdy_n = RDY_N_RESET;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    link_rst <= 1'b0;
    repeat (3) @(posedge clk);
    // Values out of reset, first read uses the reset pointer
    for (int a = 0; a < 5; a++) begin
      acc(TSR_OP_RD, 8'h00);
      acc(TSR_OP_PTR, 8'(a));
    end
    rd_word();
    // Every operating mode, ready bit seen after each mode write
    for (int md = 0; md < 4; md++) begin
      do_conv(rnd16(0));
      s = {1'($urandom), 2'(md), 1'($urandom), 4'($urandom)};
      acc(TSR_OP_PTR, ADDR_SETUP);
      acc(TSR_OP_WR, s);
      acc(TSR_OP_RD, 8'h00);
      acc(TSR_OP_PTR, ADDR_STATUS);
      acc(TSR_OP_RD, 8'h00);
    end
    // Writes to read-only and unmapped places
    foreach (ro[i]) begin
      acc(TSR_OP_PTR, ro[i]);
      acc(TSR_OP_WR, 8'($urandom));
      acc(TSR_OP_RD, 8'h00);
    end
    // Random results, limits and hysteresis in both resolutions
    repeat (24) begin
      acc(TSR_OP_PTR, ADDR_SETUP);
      acc(TSR_OP_WR, {1'($urandom), MODE_CONT, 1'($urandom), 4'h0});
      @(posedge clk);
      limits <= {rnd16(1), rnd16(1), rnd16(1), 8'($urandom_range(7, 0))};
      repeat ($urandom_range(2, 1)) do_conv(rnd16(0));
      acc(TSR_OP_PTR, ADDR_STATUS);
      acc(TSR_OP_RD, 8'h00);
      rd_word();
      acc(TSR_OP_PTR, ADDR_STATUS);
      acc(TSR_OP_RD, 8'h00);
    end
    tally_and_finish();
  end

  initial begin
    #500_000;
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    tally_and_finish();
  end

endmodule : tb_temperature_result_status_regs

`default_nettype wire
